// ### core/pmt_lookup.sv
// Page memory-type lookup with model-register and AXI4-Lite access
// Function
// - Form a 3-bit table index from three page entry flags.
// - Attribute flag is bit 7 of leaf, bit 12 of directory entry.
// - Cache-disable is bit 4, write-through bit 3 in both entry kinds.
// - Index bits: attribute 2, cache-disable 1, write-through 0.
// - Combine selected type with range type into effective type.
// - Hard reset loads WB, WT, weak-UC, UC twice over.
// - Soft init leaves the table unchanged.
// - Table read and written only at privilege level zero; the AXI4-Lite port reads and writes it without a privilege check.
// - A write with an undefined encoding faults and is discarded.
// - Lookup always applies; flags never pick a type directly.
// - Tables reused as directories select only entries zero to three; the code lets them select four to seven and flags dirHighIndex.
// - Eight 8-bit entries in one 64-bit register; upper five bits zero.
// - Decode 00,01,04,05,06,07; all others undefined.
// - The table sits at model register address 277H.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pmt_map.svh"
module pmt_lookup
    import pmt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic softInit,
    // Page walk side
    input wire logic [63:0] pageEntry,
    input wire logic isDirEntry,
    input wire logic [2:0] rangeType,
    output logic [2:0] effType,
    output logic [2:0] attrIndex,
    output logic dirHighIndex,
    // Model register instruction port
    input wire logic modelRegRead,
    input wire logic modelRegWrite,
    input wire logic [31:0] modelRegAddr,
    input wire logic [63:0] modelRegWdata,
    input wire logic [1:0] currentPrivilegeLevel,
    output logic [63:0] modelRegRdata,
    output logic modelRegHit,
    output logic generalProtectionFault,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0] effType;
        logic [2:0] attrIndex;
        logic dirHigh;
        logic [63:0] mrRdata;
        logic mrHit;
        logic gpFault;
        logic [3:0] status;
        logic [3:0] enable;
        logic [2:0] lastIdx;
        logic axiWrOnly;
        logic [11:0] awAddr;
        logic awHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic wHave;
        pmt_wr_state_t wrSt;
        logic [1:0] bresp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rresp;
    } pmt_state_t;

    pmt_state_t state_q;
    pmt_state_t state_d;
    pmt_table_if tbl ();

    pmt_table #(.ENTRIES(8)) u_table (
        .clk(clk),
        .rst(rst),
        .tbl(tbl)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic pmt_index_t formIndex(input logic [63:0] e,
                                             input logic dir);
        logic a;
        a = dir ? e[`PMT_DIR_ATTR_BIT] : e[`PMT_LEAF_ATTR_BIT];
        formIndex = {a, e[`PMT_CD_BIT], e[`PMT_WT_BIT]};
    endfunction : formIndex

    // Most restrictive type wins; strong uncacheable dominates
    function automatic logic [2:0] combineType(input logic [2:0] p,
                                               input logic [2:0] r);
        if (p == `PMT_ENC_UC || r == `PMT_ENC_UC) begin
            combineType = 3'(`PMT_ENC_UC);
        end else if (p == `PMT_ENC_UCW) begin
            combineType = (r == `PMT_ENC_WC) ? 3'(`PMT_ENC_WC) :
                3'(`PMT_ENC_UC);
        end else if (p == `PMT_ENC_WC || r == `PMT_ENC_WC) begin
            combineType = 3'(`PMT_ENC_WC);
        end else if (p == `PMT_ENC_WP || r == `PMT_ENC_WP) begin
            combineType = 3'(`PMT_ENC_WP);
        end else if (p == `PMT_ENC_WT || r == `PMT_ENC_WT) begin
            combineType = 3'(`PMT_ENC_WT);
        end else begin
            combineType = 3'(`PMT_ENC_WB);
        end
    endfunction : combineType

    function automatic logic [31:0] regRead(input logic [11:0] a,
                                            input pmt_state_t s,
                                            input logic [63:0] t);
        case (a)
            `PMT_OFF_TABLE_LO: regRead = t[31:0];
            `PMT_OFF_TABLE_HI: regRead = t[63:32];
            `PMT_OFF_STATUS: regRead = {28'h0000000, s.status};
            `PMT_OFF_ENABLE: regRead = {28'h0000000, s.enable};
            `PMT_OFF_CONTROL: regRead = {31'h00000000, s.axiWrOnly};
            `PMT_OFF_LAST_IDX: regRead = {29'h00000000, s.lastIdx};
            default: regRead = 32'h00000000;
        endcase
    endfunction : regRead

    function automatic logic regMapped(input logic [11:0] a);
        regMapped = (a == `PMT_OFF_TABLE_LO) || (a == `PMT_OFF_TABLE_HI) ||
            (a == `PMT_OFF_STATUS) || (a == `PMT_OFF_CLEAR) ||
            (a == `PMT_OFF_ENABLE) || (a == `PMT_OFF_CONTROL) ||
            (a == `PMT_OFF_LAST_IDX);
    endfunction : regMapped

    // ************************************************************
    // Next state
    // ************************************************************
    pmt_index_t idx;
    logic [2:0] selType;
    logic mrAddrHit;
    logic mrPriv;
    logic [3:0] evSet;
    logic [3:0] clrMask;
    logic [31:0] strobed;
    logic [63:0] axiTable;
    logic axiWrGo;
    logic mrWrGo;

    assign idx = formIndex(pageEntry, isDirEntry);
    assign selType = tbl.curTable[8*idx +: 3];
    assign mrAddrHit = (modelRegAddr == `PMT_MODEL_REG_ADDR);
    assign mrPriv = (currentPrivilegeLevel == 2'h0);
    assign s_axi_awready = !state_q.awHave && (state_q.wrSt == PMT_WR_IDLE);
    assign s_axi_wready = !state_q.wHave && (state_q.wrSt == PMT_WR_IDLE);
    assign s_axi_arready = !state_q.rValid;

    always_comb begin
        state_d = state_q;
        evSet = 4'h0;
        clrMask = 4'h0;
        strobed = 32'h00000000;
        axiTable = tbl.curTable;
        axiWrGo = 1'b0;
        mrWrGo = 1'b0;
        tbl.load = 1'b0;
        tbl.newTable = modelRegWdata;
        // Lookup path registered for timing
        state_d.attrIndex = idx;
        state_d.effType = combineType(selType, rangeType);
        state_d.dirHigh = isDirEntry && idx[2];
        if (isDirEntry && idx[2]) begin
            evSet[`PMT_ST_DIRHI] = 1'b1;
        end
        state_d.lastIdx = idx;
        state_d.mrHit = 1'b0;
        state_d.gpFault = 1'b0;
        // Model register instruction access
        if ((modelRegRead || modelRegWrite) && mrAddrHit) begin
            state_d.mrHit = 1'b1;
            if (!mrPriv) begin
                state_d.gpFault = 1'b1;
                evSet[`PMT_ST_PRIV] = 1'b1;
            end else if (modelRegWrite) begin
                mrWrGo = 1'b1;
                tbl.load = 1'b1;
                if (!tbl.legal) begin
                    state_d.gpFault = 1'b1;
                    evSet[`PMT_ST_FAULT] = 1'b1;
                end else begin
                    evSet[`PMT_ST_W] = 1'b1;
                end
            end else begin
                state_d.mrRdata = tbl.curTable;
            end
        end
        // AXI write: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_d.awAddr = s_axi_awaddr;
            state_d.awHave = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_d.wData = s_axi_wdata;
            state_d.wStrb = s_axi_wstrb;
            state_d.wHave = 1'b1;
        end
        case (state_q.wrSt)
            PMT_WR_IDLE: begin
                if (state_q.awHave && state_q.wHave) begin
                    axiWrGo = 1'b1;
                    state_d.awHave = 1'b0;
                    state_d.wHave = 1'b0;
                    state_d.wrSt = PMT_WR_RESP;
                    state_d.bresp = regMapped(state_q.awAddr) ?
                        `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
                end
            end
            PMT_WR_RESP: begin
                if (s_axi_bready) begin
                    state_d.wrSt = PMT_WR_IDLE;
                end
            end
            default: state_d.wrSt = PMT_WR_IDLE;
        endcase
        for (int b = 0; b < 4; b++) begin
            strobed[8*b +: 8] = state_q.wStrb[b] ?
                state_q.wData[8*b +: 8] : 8'h00;
        end
        // The model register port has priority over a bus table write
        if (axiWrGo) begin
            case (state_q.awAddr)
                `PMT_OFF_TABLE_LO, `PMT_OFF_TABLE_HI: begin
                    for (int b = 0; b < 4; b++) begin
                        if (state_q.wStrb[b]) begin
                            if (state_q.awAddr == `PMT_OFF_TABLE_LO) begin
                                axiTable[8*b +: 8] = strobed[8*b +: 8];
                            end else begin
                                axiTable[32+8*b +: 8] = strobed[8*b +: 8];
                            end
                        end
                    end
                    if (!state_q.axiWrOnly && !mrWrGo) begin
                        tbl.load = 1'b1;
                        tbl.newTable = axiTable;
                        if (!tbl.legal) begin
                            evSet[`PMT_ST_FAULT] = 1'b1;
                            state_d.bresp = `PMT_RESP_SLVERR;
                        end else begin
                            evSet[`PMT_ST_W] = 1'b1;
                        end
                    end else begin
                        state_d.bresp = `PMT_RESP_SLVERR;
                    end
                end
                `PMT_OFF_CLEAR: clrMask = strobed[3:0];
                `PMT_OFF_ENABLE: state_d.enable = strobed[3:0];
                `PMT_OFF_CONTROL: state_d.axiWrOnly = strobed[0];
                default: ;
            endcase
        end
        // A new event wins over a clear in the same cycle
        state_d.status = (state_q.status & ~clrMask) | evSet;
        // AXI read
        if (state_q.rValid && s_axi_rready) begin
            state_d.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_d.rValid = 1'b1;
            state_d.rData = regRead(s_axi_araddr, state_q, tbl.curTable);
            state_d.rresp = regMapped(s_axi_araddr) ?
                `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
        end
    end

    // Soft init is a processor event only; it leaves all state alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign effType = state_q.effType;
    assign attrIndex = state_q.attrIndex;
    assign dirHighIndex = state_q.dirHigh;
    assign modelRegRdata = state_q.mrRdata;
    assign modelRegHit = state_q.mrHit;
    assign generalProtectionFault = state_q.gpFault;
    assign s_axi_bvalid = (state_q.wrSt == PMT_WR_RESP);
    assign s_axi_bresp = state_q.bresp;
    assign s_axi_rvalid = state_q.rValid;
    assign s_axi_rdata = state_q.rData;
    assign s_axi_rresp = state_q.rresp;
    assign irq = |(state_q.status & state_q.enable);

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_mr_unpriv;
        (modelRegRead || modelRegWrite) && mrAddrHit && !mrPriv;
    endsequence

    a_index_form: assert property (
        @(posedge clk) disable iff (rst)
        1 |=> attrIndex == {$past(isDirEntry) ?
            $past(pageEntry[`PMT_DIR_ATTR_BIT]) :
            $past(pageEntry[`PMT_LEAF_ATTR_BIT]),
            $past(pageEntry[`PMT_CD_BIT]), $past(pageEntry[`PMT_WT_BIT])})
        else $error("index not formed from entry flags");
    a_priv_fault: assert property (
        @(posedge clk) disable iff (rst)
        s_mr_unpriv |=> generalProtectionFault ##0 $stable(tbl.curTable))
        else $error("unprivileged access not faulted");
    a_uc_dominates: assert property (
        @(posedge clk) disable iff (rst)
        (rangeType == 3'h0) |=> effType == 3'h0)
        else $error("uncacheable range not honoured");
    a_soft_keep: assert property (
        @(posedge clk) disable iff (rst)
        (softInit && !tbl.load) |=> $stable(tbl.curTable))
        else $error("soft init changed the table");
    a_illegal_gp: assert property (
        @(posedge clk) disable iff (rst)
        (modelRegWrite && mrAddrHit && mrPriv && !tbl.legal)
        |=> generalProtectionFault)
        else $error("illegal encoding not faulted");
    a_read_full: assert property (
        @(posedge clk) disable iff (rst)
        (modelRegRead && !modelRegWrite && mrAddrHit && mrPriv)
        |=> modelRegRdata == $past(tbl.curTable))
        else $error("read did not return whole table");
    a_dir_high: assert property (
        @(posedge clk) disable iff (rst)
        (isDirEntry && pageEntry[`PMT_DIR_ATTR_BIT]) |=> dirHighIndex)
        else $error("directory high index not flagged");
    a_bresp_hold: assert property (
        @(posedge clk) disable iff (rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule : pmt_lookup

// ### core/pmt_table.sv
// Holder of the eight-entry type table with legality check
`timescale 1ns/1ps
`include "pmt_map.svh"
module pmt_table
    import pmt_pkg::*;
#(
    parameter int ENTRIES = 8
) (
    input wire logic clk,
    input wire logic rst,
    pmt_table_if.holder tbl
);
    // ************************************************************
    // Check and storage
    // ************************************************************
    generate
        if (ENTRIES != 8) begin : g_bad_entries
            $error("pmt_table supports eight entries only");
        end
    endgenerate

    function automatic logic entryLegal(input pmt_entry_t e);
        entryLegal = (e == `PMT_ENC_UC) || (e == `PMT_ENC_WC) ||
            (e == `PMT_ENC_WT) || (e == `PMT_ENC_WP) ||
            (e == `PMT_ENC_WB) || (e == `PMT_ENC_UCW);
    endfunction : entryLegal

    typedef struct packed {
        logic [63:0] curTable;
    } pmt_tstate_t;

    pmt_tstate_t state_q;
    pmt_tstate_t state_d;
    logic [ENTRIES-1:0] okEach;

    generate
        for (genvar i = 0; i < ENTRIES; i++) begin : g_chk
            assign okEach[i] = entryLegal(tbl.newTable[8*i +: 8]);
        end
    endgenerate

    assign tbl.legal = &okEach;
    assign tbl.curTable = state_q.curTable;

    always_comb begin
        state_d = state_q;
        if (tbl.load && tbl.legal) begin
            state_d.curTable = tbl.newTable;
        end
    end

    // Soft init never reaches here; only the hard reset reloads defaults
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q.curTable <= `PMT_TABLE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    a_reject_illegal: assert property (
        @(posedge clk) disable iff (rst)
        (tbl.load && !tbl.legal) |=> $stable(state_q.curTable))
        else $error("illegal table write changed the table");
endmodule : pmt_table

// ### inc/pmt_map.svh
// Offsets, field positions, encodings and reset values of the lookup block
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH
`define PMT_MODEL_REG_ADDR 32'h0000_0277
`define PMT_OFF_TABLE_LO 12'h000
`define PMT_OFF_TABLE_HI 12'h004
`define PMT_OFF_STATUS 12'h008
`define PMT_OFF_CLEAR 12'h00C
`define PMT_OFF_ENABLE 12'h010
`define PMT_OFF_CONTROL 12'h014
`define PMT_OFF_LAST_IDX 12'h018
`define PMT_LEAF_ATTR_BIT 7
`define PMT_DIR_ATTR_BIT 12
`define PMT_CD_BIT 4
`define PMT_WT_BIT 3
`define PMT_ENC_UC 8'h00
`define PMT_ENC_WC 8'h01
`define PMT_ENC_WT 8'h04
`define PMT_ENC_WP 8'h05
`define PMT_ENC_WB 8'h06
`define PMT_ENC_UCW 8'h07
`define PMT_TABLE_RESET 64'h0007_0406_0007_0406
`define PMT_ST_FAULT 0
`define PMT_ST_PRIV 1
`define PMT_ST_DIRHI 2
`define PMT_ST_W 3
`define PMT_RESP_OKAY 2'h0
`define PMT_RESP_SLVERR 2'h2
`endif

// ### inc/pmt_pkg.sv
// Types shared by the lookup block modules
package pmt_pkg;
    typedef logic [7:0] pmt_entry_t;
    typedef logic [2:0] pmt_index_t;
    typedef enum logic [1:0] {
        PMT_WR_IDLE,
        PMT_WR_RESP
    } pmt_wr_state_t;
endpackage : pmt_pkg

// ### inc/pmt_table_if.sv
// Connection between the table holder and the register front end
`timescale 1ns/1ps
interface pmt_table_if;
    logic [63:0] curTable;
    logic [63:0] newTable;
    logic load;
    logic legal;
    modport holder (output curTable, output legal, input newTable,
                    input load);
    modport user (input curTable, input legal, output newTable,
                  output load);
endinterface : pmt_table_if

// ### tb/pmt_walk_model.sv
// Page walk model that presents page entries to the lookup block
`timescale 1ns/1ps
`include "pmt_map.svh"
module pmt_walk_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic attrFlag,
    input wire logic cdFlag,
    input wire logic wtFlag,
    input wire logic dirSel,
    input wire logic [2:0] rangeIn,
    output logic [63:0] pageEntry,
    output logic isDirEntry,
    output logic [2:0] rangeType
);
    logic [63:0] noise_q;
    logic [63:0] entry;
    // Bits outside the flags flip every cycle, except bit 7 held at 1 for directory entries, so a wrong tap shows up
    always_comb begin
        entry = noise_q;
        entry[`PMT_CD_BIT] = cdFlag;
        entry[`PMT_WT_BIT] = wtFlag;
        if (dirSel) begin
            entry[`PMT_DIR_ATTR_BIT] = attrFlag;
            entry[`PMT_LEAF_ATTR_BIT] = 1'b1;
        end else begin
            entry[`PMT_LEAF_ATTR_BIT] = attrFlag;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            noise_q <= 64'hA5C3_5A3C_F00F_0FF0;
            pageEntry <= 64'h0;
            isDirEntry <= 1'b0;
            rangeType <= 3'h0;
        end else begin
            noise_q <= ~noise_q;
            pageEntry <= entry;
            isDirEntry <= dirSel;
            rangeType <= rangeIn;
        end
    end
endmodule : pmt_walk_model

// ### tb/tb_page_memory_type_lookup.sv
// Self-checking bench for the page memory-type lookup block
`timescale 1ns/1ps
`include "pmt_map.svh"
module tb_page_memory_type_lookup;
    logic clk = 1'b0, rst = 1'b1, softInit = 1'b0;
    logic attrFlag = 1'b0, cdFlag = 1'b0, wtFlag = 1'b0, dirSel = 1'b0;
    logic [2:0] rangeIn = 3'h0;
    logic [63:0] pageEntry;
    logic isDirEntry, dirHighIndex, modelRegHit, generalProtectionFault;
    logic [2:0] rangeType, effType, attrIndex;
    logic modelRegRead = 1'b0, modelRegWrite = 1'b0;
    logic [31:0] modelRegAddr = 32'h0;
    logic [63:0] modelRegWdata = 64'h0, modelRegRdata, tblExp;
    logic [1:0] currentPrivilegeLevel = 2'h0, s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    int n_mismatch = 0, num_checks = 0;

    pmt_walk_model walker (.clk(clk), .rst(rst), .attrFlag(attrFlag),
        .cdFlag(cdFlag), .wtFlag(wtFlag), .dirSel(dirSel),
        .rangeIn(rangeIn), .pageEntry(pageEntry),
        .isDirEntry(isDirEntry), .rangeType(rangeType));

    pmt_lookup uut (.clk(clk), .rst(rst), .softInit(softInit),
        .pageEntry(pageEntry), .isDirEntry(isDirEntry),
        .rangeType(rangeType), .effType(effType), .attrIndex(attrIndex),
        .dirHighIndex(dirHighIndex), .modelRegRead(modelRegRead),
        .modelRegWrite(modelRegWrite), .modelRegAddr(modelRegAddr),
        .modelRegWdata(modelRegWdata),
        .currentPrivilegeLevel(currentPrivilegeLevel),
        .modelRegRdata(modelRegRdata), .modelRegHit(modelRegHit),
        .generalProtectionFault(generalProtectionFault),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq));

    initial forever #5 clk = ~clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("Mismatches %0d, checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // ******************************
    // Bus and port tasks
    // ******************************
    // Answer outputs stand one cycle, so they are sampled just after it
    task automatic mreg(input logic wr, input logic [31:0] a,
                        input logic [63:0] d, input logic [1:0] current_privilege_level);
        @(posedge clk);
        modelRegRead <= !wr;
        modelRegWrite <= wr;
        modelRegAddr <= a;
        modelRegWdata <= d;
        currentPrivilegeLevel <= current_privilege_level;
        @(posedge clk);
        modelRegRead <= 1'b0;
        modelRegWrite <= 1'b0;
        #1;
    endtask : mreg

    task automatic rd_tbl();
        mreg(1'b0, `PMT_MODEL_REG_ADDR, 64'h0, 2'h0);
        check(modelRegHit, 1'b1);
        check(generalProtectionFault, 1'b0);
        check(modelRegRdata, tblExp);
    endtask : rd_tbl

    task automatic wr_tbl(input logic [63:0] v);
        mreg(1'b1, `PMT_MODEL_REG_ADDR, v, 2'h0);
        check(generalProtectionFault, 1'b0);
        tblExp = v;
        rd_tbl();
    endtask : wr_tbl

    // Handshake levels are settled at the falling edge and stand until
    // the rising edge that takes them, so they are sampled there
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        bit awDone, wDone, awHit, wHit, bDone;
        logic [1:0] resp;
        awDone = 0;
        wDone = 0;
        bDone = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bDone) begin
            @(negedge clk);
            awHit = !awDone && s_axi_awready === 1'b1;
            wHit = !wDone && s_axi_wready === 1'b1;
            bDone = s_axi_bvalid === 1'b1;
            resp = s_axi_bresp;
            @(posedge clk);
            if (awHit) begin
                awDone = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (wHit) begin
                wDone = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        check(resp, er);
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        bit arDone, arHit, rDone;
        logic [31:0] dat;
        logic [1:0] resp;
        arDone = 0;
        rDone = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rDone) begin
            @(negedge clk);
            arHit = !arDone && s_axi_arready === 1'b1;
            rDone = s_axi_rvalid === 1'b1;
            dat = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk);
            if (arHit) begin
                arDone = 1;
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        check(dat, ed);
        check(resp, er);
    endtask : axi_rd

    // ******************************
    // Scenarios
    // ******************************
    // Range type equal to the entry type leaves the merge result unchanged,
    // except weak uncached, which a non-combining range makes strong
    task automatic t_lookups();
        logic [2:0] e;
        for (int i = 0; i < 16; i++) begin
            e = tblExp[8 * (i % 8) +: 3];
            @(posedge clk);
            attrFlag <= i[2];
            cdFlag <= i[1];
            wtFlag <= i[0];
            dirSel <= i[3];
            rangeIn <= e;
            repeat (3) @(posedge clk);
            #1;
            check(attrIndex, i[2:0]);
            check(effType, (e == `PMT_ENC_UCW) ? `PMT_ENC_UC : e);
            check(effType[2:0], e == `PMT_ENC_UCW ? 3'h0 : e);
            check(dirHighIndex, i[3] & i[2]);
        end
        @(posedge clk);
        {attrFlag, cdFlag, wtFlag, dirSel} <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : t_lookups

    task automatic t_refuse();
        logic [7:0] bad [4];
        logic [63:0] v;
        bad = '{8'h02, 8'h03, 8'h08, 8'h80};
        for (int i = 0; i < 4; i++) begin
            v = tblExp ^ 64'h0100_0000_0000_0000;
            v[16 * i +: 8] = bad[i];
            mreg(1'b1, `PMT_MODEL_REG_ADDR, v, 2'h0);
            check(generalProtectionFault, 1'b1);
        end
        mreg(1'b1, `PMT_MODEL_REG_ADDR, tblExp ^ 64'h1, 2'h3);
        check(generalProtectionFault, 1'b1);
        mreg(1'b0, `PMT_MODEL_REG_ADDR, 64'h0, 2'h1);
        check(generalProtectionFault, 1'b1);
        rd_tbl();
    endtask : t_refuse

    task automatic t_axi();
        axi_rd(12'h100, 32'h0, `PMT_RESP_SLVERR);
        axi_wr(12'h100, 32'h1, `PMT_RESP_SLVERR);
        axi_wr(`PMT_OFF_TABLE_LO, {tblExp[31:8], 8'h02},
            `PMT_RESP_SLVERR);
        axi_wr(`PMT_OFF_TABLE_HI, 32'h0105_0104, `PMT_RESP_OKAY);
        tblExp[63:32] = 32'h0105_0104;
        axi_rd(`PMT_OFF_TABLE_HI, 32'h0105_0104, `PMT_RESP_OKAY);
        axi_wr(`PMT_OFF_CONTROL, 32'h1, `PMT_RESP_OKAY);
        axi_wr(`PMT_OFF_TABLE_LO, 32'h0, `PMT_RESP_SLVERR);
        axi_wr(`PMT_OFF_CONTROL, 32'h0, `PMT_RESP_OKAY);
        rd_tbl();
        mreg(1'b0, 32'h0000_0276, 64'h0, 2'h0);
        check(modelRegHit, 1'b0);
    endtask : t_axi

    task automatic t_irq();
        axi_wr(`PMT_OFF_CLEAR, 32'hF, `PMT_RESP_OKAY);
        axi_rd(`PMT_OFF_STATUS, 32'h0, `PMT_RESP_OKAY);
        axi_wr(`PMT_OFF_ENABLE, 32'h1, `PMT_RESP_OKAY);
        axi_rd(`PMT_OFF_ENABLE, 32'h1, `PMT_RESP_OKAY);
        check(irq, 1'b0);
        mreg(1'b1, `PMT_MODEL_REG_ADDR, {tblExp[63:8], 8'h03}, 2'h0);
        axi_rd(`PMT_OFF_STATUS, 32'h1, `PMT_RESP_OKAY);
        check(irq, 1'b1);
        mreg(1'b1, `PMT_MODEL_REG_ADDR, tblExp, 2'h3);
        axi_rd(`PMT_OFF_STATUS, 32'h3, `PMT_RESP_OKAY);
        axi_wr(`PMT_OFF_CLEAR, 32'h1, `PMT_RESP_OKAY);
        axi_rd(`PMT_OFF_STATUS, 32'h2, `PMT_RESP_OKAY);
        check(irq, 1'b0);
    endtask : t_irq

    // ******************************
    // Main sequence
    // ******************************
    initial begin
        tblExp = `PMT_TABLE_RESET;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_tbl();
        axi_rd(`PMT_OFF_TABLE_LO, 32'h0007_0406, `PMT_RESP_OKAY);
        t_lookups();
        wr_tbl(64'h0706_0504_0100_0706);
        t_lookups();
        t_refuse();
        @(posedge clk);
        softInit <= 1'b1;
        repeat (5) @(posedge clk);
        softInit <= 1'b0;
        rd_tbl();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tblExp = `PMT_TABLE_RESET;
        rd_tbl();
        t_axi();
        t_irq();
        close_out();
    end

    // A hung handshake would otherwise stall the run forever
    initial begin
        #200us;
        n_mismatch++;
        close_out();
    end
endmodule : tb_page_memory_type_lookup
